//--- rtl/cfg_consts.svh
// offsets, fields, reset values and decode constants of the strap front end
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

`define NUM_CH 8
`define CFG_W 21

// register offsets on the bus
`define OFF_CTRL 8'h00
`define OFF_SERCFG 8'h04
`define OFF_STATUS 8'h08
`define OFF_ACTIVE 8'h0C
`define OFF_RATIO 8'h10

// control register strobes
`define CTRL_SOFT_RST 0
`define CTRL_SOFT_SYNC 1

// configuration word fields
`define F_FILT 0
`define F_RATIO_LO 1
`define F_RATIO_HI 2
`define F_LAY_LO 3
`define F_LAY_HI 4
`define F_AIN_LO 8
`define F_AIN_HI 15
`define F_REF_LO 16
`define F_REF_HI 23

// status register fields
`define S_SERIAL 0
`define S_STATE_LO 1
`define S_STATE_HI 2
`define S_READY 3
`define S_PENDING 4

// reset values
`define SERCFG_RESET 32'h0000FF00
`define ACTIVE_RESET 21'h000000
`define PIN_IDLE 9'h007
`define SYNC_IDLE 2'h3
`define ALL_ON 8'hFF
`define ALL_OFF 8'h00
`define WORD_ZERO 32'h00000000
`define HRESP_OKAY 1'b0

// ratio strap codes and their ratios
`define RCODE_32 2'h0
`define RCODE_64 2'h1
`define RCODE_128 2'h2
`define RCODE_1024 2'h3
`define RATIO_32 11'h020
`define RATIO_64 11'h040
`define RATIO_128 11'h080
`define RATIO_1024 11'h400

// output layout code meaning one lane per channel
`define LAYOUT_PER_LANE 2'h0

`endif

//--- rtl/cfg_pkg.sv
// types and shared decode functions of the strap front end
`default_nettype none
`include "cfg_consts.svh"
package cfg_pkg;

    // control sequence, gray along sample, wait, reset, run
    typedef enum logic [1:0] {
        ST_SAMPLE = 2'h0,
        ST_NEED_RST = 2'h1,
        ST_RESETTING = 2'h3,
        ST_RUN = 2'h2
    } ctl_state_e;

    typedef enum logic {
        FILT_WIDEBAND = 1'b0,
        FILT_SINC5 = 1'b1
    } filter_e;

    typedef struct packed {
        filter_e filt;
        logic [1:0] ratio_code;
        logic [1:0] layout;
        logic [`NUM_CH-1:0] ain_pre;
        logic [`NUM_CH-1:0] ref_pre;
    } cfg_s;

    // ratio strap code to decimation ratio
    function automatic logic [10:0] ratio_of(input logic [1:0] code);
        case (code)
            `RCODE_32: ratio_of = `RATIO_32;
            `RCODE_64: ratio_of = `RATIO_64;
            `RCODE_128: ratio_of = `RATIO_128;
            default: ratio_of = `RATIO_1024;
        endcase
    endfunction : ratio_of

    // bus word to configuration
    function automatic cfg_s word_to_cfg(input logic [31:0] w);
        cfg_s c;
        c.filt = filter_e'(w[`F_FILT]);
        c.ratio_code = w[`F_RATIO_HI:`F_RATIO_LO];
        c.layout = w[`F_LAY_HI:`F_LAY_LO];
        c.ain_pre = w[`F_AIN_HI:`F_AIN_LO];
        c.ref_pre = w[`F_REF_HI:`F_REF_LO];
        return c;
    endfunction : word_to_cfg

    // configuration to bus word, unused bits zero
    function automatic logic [31:0] cfg_to_word(input cfg_s c);
        logic [31:0] w;
        w = `WORD_ZERO;
        w[`F_FILT] = c.filt;
        w[`F_RATIO_HI:`F_RATIO_LO] = c.ratio_code;
        w[`F_LAY_HI:`F_LAY_LO] = c.layout;
        w[`F_AIN_HI:`F_AIN_LO] = c.ain_pre;
        w[`F_REF_HI:`F_REF_LO] = c.ref_pre;
        return w;
    endfunction : cfg_to_word

endpackage : cfg_pkg
`default_nettype wire

//--- rtl/strap_if.sv
// registered strap levels and sync event passed inside the block
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
    logic valid;
    logic ctrl_sel;
    logic filt;
    logic [1:0] ratio_code;
    logic [1:0] layout;
    logic sync_evt;
    logic hard_rst;

    modport sampler (
        output valid, ctrl_sel, filt, ratio_code, layout, sync_evt, hard_rst
    );
    modport user (
        input valid, ctrl_sel, filt, ratio_code, layout, sync_evt, hard_rst
    );
endinterface : strap_if
`default_nettype wire

//--- rtl/strap_sampler.sv
// registers the strap pins and finds start and sync request pulses
`timescale 1ns/1ps
`default_nettype none
module strap_sampler
    import cfg_pkg::*;
(
    input wire logic hclk, // block clock
    input wire logic hresetn, // async reset, low
    input wire logic ce, // clock enable
    input wire logic ctrl_select_pin, // 0 pin, 1 serial
    input wire logic filter_sel_pin, // 1 sinc5
    input wire logic ratio_strap_hi, // ratio code bit 1
    input wire logic ratio_strap_lo, // ratio code bit 0
    input wire logic output_layout_strap_hi, // layout bit 1
    input wire logic output_layout_strap_lo, // layout bit 0
    input wire logic start_n, // start pulse, low
    input wire logic sync_req_n, // sync request, low
    input wire logic hard_reset_n, // hard reset pin, low
    strap_if.sampler straps // registered straps
);

    logic [8:0] pin_reg;
    logic [8:0] pin_next;
    logic [1:0] prev_reg;
    logic [1:0] prev_next;
    logic valid_reg;
    logic valid_next;

    // capture all pins each enabled cycle
    always_comb begin
        pin_next = {ctrl_select_pin, filter_sel_pin, ratio_strap_hi,
                    ratio_strap_lo, output_layout_strap_hi,
                    output_layout_strap_lo, start_n, sync_req_n,
                    hard_reset_n};
        prev_next = pin_reg[2:1];
        valid_next = 1'b1;
    end

    // pin and edge history registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_reg <= `PIN_IDLE;
            prev_reg <= `SYNC_IDLE;
            valid_reg <= 1'b0;
        end else if (ce) begin
            pin_reg <= pin_next;
            prev_reg <= prev_next;
            valid_reg <= valid_next;
        end
    end

    // a falling edge on either start or sync request is one event
    assign straps.sync_evt = |(prev_reg & ~pin_reg[2:1]);
    assign straps.valid = valid_reg;
    assign straps.ctrl_sel = pin_reg[8];
    assign straps.filt = pin_reg[7];
    assign straps.ratio_code = pin_reg[6:5];
    assign straps.layout = pin_reg[4:3];
    assign straps.hard_rst = ~pin_reg[0];

endmodule : strap_sampler
`default_nettype wire

//--- rtl/config_shadow.sv
// shadow copy of the configuration that the converters really use
`timescale 1ns/1ps
`default_nettype none
module config_shadow
    import cfg_pkg::*;
(
    input wire logic hclk, // block clock
    input wire logic hresetn, // async reset, low
    input wire logic ce, // clock enable
    input wire logic load, // take src this cycle
    input wire cfg_s src, // candidate configuration
    output cfg_s active, // applied configuration
    output logic [10:0] ratio, // applied decimation ratio
    output logic applied // one cycle after each load
);

    cfg_s active_reg;
    cfg_s active_next;
    logic [10:0] ratio_reg;
    logic [10:0] ratio_next;
    logic applied_reg;
    logic applied_next;

    // hold unless a load arrives
    always_comb begin
        active_next = active_reg;
        ratio_next = ratio_reg;
        applied_next = 1'b0;
        if (load) begin
            active_next = src;
            ratio_next = ratio_of(src.ratio_code);
            applied_next = 1'b1;
        end
    end

    // shadow registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_reg <= cfg_s'(`ACTIVE_RESET);
            ratio_reg <= `RATIO_32;
            applied_reg <= 1'b0;
        end else if (ce) begin
            active_reg <= active_next;
            ratio_reg <= ratio_next;
            applied_reg <= applied_next;
        end
    end

    assign active = active_reg;
    assign ratio = ratio_reg;
    assign applied = applied_reg;

endmodule : config_shadow
`default_nettype wire

//--- rtl/adc_pin_strap_config.sv
// top of the converter configuration front end with its bus registers
`timescale 1ns/1ps
`default_nettype none
module adc_pin_strap_config
    import cfg_pkg::*;
(
    input wire logic hclk, // block clock, 125 MHz
    input wire logic hresetn, // power-up reset, low
    input wire logic ce, // clock enable
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic [31:0] hrdata, // read data
    output logic hresp, // always okay
    input wire logic ctrl_select_pin, // 0 pin, 1 serial
    input wire logic filter_sel_pin, // 1 sinc5, 0 wideband
    input wire logic ratio_strap_hi, // ratio code bit 1
    input wire logic ratio_strap_lo, // ratio code bit 0
    input wire logic output_layout_strap_hi, // layout bit 1
    input wire logic output_layout_strap_lo, // layout bit 0
    input wire logic start_n, // start pulse, low
    input wire logic sync_req_n, // sync request, low
    input wire logic hard_reset_n, // hard reset, low
    output logic serial_ctrl_mode, // fixed control method
    output logic cfg_ready, // running after reset
    output logic filter_sinc5, // applied filter
    output logic [10:0] dec_ratio, // applied ratio
    output logic [1:0] layout_code, // applied layout code
    output logic serial_result_lanes_shared, // lanes time shared
    output logic [`NUM_CH-1:0] ain_precharge_en, // input buffers
    output logic [`NUM_CH-1:0] ref_precharge_en, // reference buffers
    output logic cfg_apply // one cycle per apply
);

    strap_if straps ();

    // bus slave state
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_addr_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    cfg_s sercfg_reg;
    cfg_s sercfg_next;

    // control sequence state
    ctl_state_e state_reg;
    ctl_state_e state_next;
    logic serial_mode_reg;
    logic serial_mode_next;

    // shared combinational terms
    logic addr_phase;
    logic wr_ctrl;
    logic soft_rst;
    logic soft_sync;
    logic rst_req;
    logic sync_any;
    logic load;
    logic pending;
    cfg_s pin_cfg;
    cfg_s src_cfg;
    cfg_s active_cfg;
    logic [10:0] active_ratio;
    logic applied;

    // strap pins into the clock domain
    strap_sampler u_sampler (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .ctrl_select_pin(ctrl_select_pin),
        .filter_sel_pin(filter_sel_pin),
        .ratio_strap_hi(ratio_strap_hi),
        .ratio_strap_lo(ratio_strap_lo),
        .output_layout_strap_hi(output_layout_strap_hi),
        .output_layout_strap_lo(output_layout_strap_lo),
        .start_n(start_n),
        .sync_req_n(sync_req_n),
        .hard_reset_n(hard_reset_n),
        .straps(straps.sampler)
    );

    // applied configuration, changed only on load
    config_shadow u_shadow (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .load(load),
        .src(src_cfg),
        .active(active_cfg),
        .ratio(active_ratio),
        .applied(applied)
    );

    // bus handshake, no wait states while enabled
    assign addr_phase = hsel & htrans[1] & hready & ce;
    assign hreadyout = ce;
    assign hresp = `HRESP_OKAY;
    assign hrdata = rdata_reg;

    // control strobes written in a data phase
    assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `OFF_CTRL);
    assign soft_rst = wr_ctrl & hwdata[`CTRL_SOFT_RST];
    assign soft_sync = wr_ctrl & hwdata[`CTRL_SOFT_SYNC];
    assign rst_req = soft_rst | straps.hard_rst;
    assign sync_any = straps.sync_evt | soft_sync;

    // pin control configuration from strap levels, input buffers all on, reference buffers off
    always_comb begin
        pin_cfg.filt = filter_e'(straps.filt);
        pin_cfg.ratio_code = straps.ratio_code;
        pin_cfg.layout = straps.layout;
        pin_cfg.ain_pre = `ALL_ON;
        pin_cfg.ref_pre = `ALL_OFF;
    end

    // source picked by the control method fixed at power-up
    assign src_cfg = serial_mode_reg ? sercfg_reg : pin_cfg;

    // apply at reset exit, or on a sync event while running
    // one load as the reset is let go, not on every cycle held in reset
    assign load = ((state_reg == ST_RESETTING) & !rst_req) |
                  ((state_reg == ST_RUN) & sync_any);

    // a strap or register change is waiting for its sync
    assign pending = (src_cfg != active_cfg);

    // control sequence next state
    always_comb begin
        state_next = state_reg;
        serial_mode_next = serial_mode_reg;
        case (state_reg)
            ST_SAMPLE: begin
                if (straps.valid) begin
                    serial_mode_next = straps.ctrl_sel;
                    state_next = ST_NEED_RST;
                end
            end
            ST_NEED_RST: begin
                if (rst_req) begin
                    state_next = ST_RESETTING;
                end
            end
            ST_RESETTING: begin
                if (!rst_req) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (rst_req) begin
                    state_next = ST_RESETTING;
                end
            end
            default: begin
                state_next = ST_SAMPLE;
            end
        endcase
    end

    // control sequence registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_SAMPLE;
            serial_mode_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            serial_mode_reg <= serial_mode_next;
        end
    end

    // bus slave next values and read mux
    always_comb begin
        wr_pend_next = addr_phase & hwrite;
        wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
        sercfg_next = sercfg_reg;
        if (state_next == ST_RESETTING) begin
            sercfg_next = word_to_cfg(`SERCFG_RESET);
        end else if (wr_pend_reg && (wr_addr_reg == `OFF_SERCFG)) begin
            sercfg_next = word_to_cfg(hwdata);
        end
        rdata_next = rdata_reg;
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                `OFF_SERCFG: begin
                    rdata_next = cfg_to_word(sercfg_next);
                end
                `OFF_STATUS: begin
                    rdata_next = `WORD_ZERO;
                    rdata_next[`S_SERIAL] = serial_mode_reg;
                    rdata_next[`S_STATE_HI:`S_STATE_LO] = state_reg;
                    rdata_next[`S_READY] = (state_reg == ST_RUN);
                    rdata_next[`S_PENDING] = pending;
                end
                `OFF_ACTIVE: begin
                    rdata_next = cfg_to_word(active_cfg);
                end
                `OFF_RATIO: begin
                    rdata_next = {21'h000000, active_ratio};
                end
                default: begin
                    rdata_next = `WORD_ZERO;
                end
            endcase
        end
    end

    // bus slave registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= `OFF_CTRL;
            rdata_reg <= `WORD_ZERO;
            sercfg_reg <= word_to_cfg(`SERCFG_RESET);
        end else if (ce) begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
            sercfg_reg <= sercfg_next;
        end
    end

    // configuration levels toward the converters, results never pass here
    assign serial_ctrl_mode = serial_mode_reg;
    assign cfg_ready = (state_reg == ST_RUN);
    assign filter_sinc5 = (active_cfg.filt == FILT_SINC5);
    assign dec_ratio = active_ratio;
    assign layout_code = active_cfg.layout;
    assign serial_result_lanes_shared =
        (active_cfg.layout != `LAYOUT_PER_LANE);
    assign ain_precharge_en = active_cfg.ain_pre;
    assign ref_precharge_en = active_cfg.ref_pre;
    assign cfg_apply = applied;

endmodule : adc_pin_strap_config
`default_nettype wire

//--- testbench/adc_pin_strap_config_assertions.sv
// concurrent checks on the strap front end ports
`timescale 1ns/1ps
`default_nettype none
`include "cfg_consts.svh"
module adc_pin_strap_config_assertions (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, low
    input wire logic ce, // clock enable
    input wire logic start_n, // start, low
    input wire logic filter_sel_pin, // filter strap
    input wire logic ratio_strap_hi, // ratio bit 1
    input wire logic ratio_strap_lo, // ratio bit 0
    input wire logic serial_ctrl_mode, // fixed method
    input wire logic cfg_ready, // running
    input wire logic filter_sinc5, // applied filter
    input wire logic [10:0] dec_ratio, // applied ratio
    input wire logic [1:0] layout_code, // applied layout
    input wire logic serial_result_lanes_shared, // shared lanes
    input wire logic [`NUM_CH-1:0] ain_precharge_en, // input buffers
    input wire logic [`NUM_CH-1:0] ref_precharge_en, // ref buffers
    input wire logic cfg_apply // apply pulse
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic pin_apply;
    // apply while under strap control
    assign pin_apply = cfg_apply && !serial_ctrl_mode;

    property p_filt;
        pin_apply |-> filter_sinc5 == $past(filter_sel_pin, 2);
    endproperty
    a_filt: assert property (p_filt)
        else $error("filter differs from strap");
    property p_ratio;
        pin_apply |-> dec_ratio == (({ratio_strap_hi, ratio_strap_lo} == 2'h3)
            ? 11'h400 : (11'h020 << {ratio_strap_hi, ratio_strap_lo}));
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("ratio differs from strap");
    property p_ain;
        pin_apply |-> ain_precharge_en == {`NUM_CH{1'b1}};
    endproperty
    a_ain: assert property (p_ain)
        else $error("input buffers not all on");
    property p_ref;
        pin_apply |-> ref_precharge_en == {`NUM_CH{1'b0}};
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference buffers not off");
    property p_lanes;
        serial_result_lanes_shared == (layout_code != 2'h0);
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("lane sharing differs from layout");
    property p_hold;
        !cfg_apply |-> $stable({filter_sinc5, dec_ratio, layout_code});
    endproperty
    a_hold: assert property (p_hold)
        else $error("config changed without apply");
    property p_mode;
        $past(cfg_ready) |-> $stable(serial_ctrl_mode);
    endproperty
    a_mode: assert property (p_mode)
        else $error("control method changed");
    property p_sync;
        cfg_ready && ce && $fell(start_n) |-> ##2 cfg_apply;
    endproperty
    a_sync: assert property (p_sync)
        else $error("start pulse not applied");
    property p_early;
        cfg_apply |-> cfg_ready;
    endproperty
    a_early: assert property (p_early)
        else $error("apply before reset");
    c_pin: cover property (pin_apply);
    c_ser: cover property (cfg_apply && serial_ctrl_mode);
    c_big: cover property (cfg_apply && dec_ratio == 11'h400);
endmodule : adc_pin_strap_config_assertions
`default_nettype wire

//--- testbench/strap_host_model.sv
// board straps and host pulses on the far side of the front end
`timescale 1ns/1ps
`default_nettype none
module strap_host_model (
    input wire logic hclk, // clock
    output var logic ctrl_select_pin, // method strap
    output var logic filter_sel_pin, // filter strap
    output var logic ratio_strap_hi, // ratio bit 1
    output var logic ratio_strap_lo, // ratio bit 0
    output var logic output_layout_strap_hi, // layout bit 1
    output var logic output_layout_strap_lo, // layout bit 0
    output var logic start_n, // start, low
    output var logic sync_req_n, // sync request, low
    output var logic hard_reset_n // hard reset, low
);
    // idle levels from time zero
    initial begin
        ctrl_select_pin = 1'b0;
        {filter_sel_pin, ratio_strap_hi, ratio_strap_lo} = 3'h0;
        {output_layout_strap_hi, output_layout_strap_lo} = 2'h0;
        {start_n, sync_req_n, hard_reset_n} = 3'h7;
    end
    // new strap levels {filter, ratio, layout}
    task automatic set_straps(input logic [4:0] v);
        @(posedge hclk);
        {filter_sel_pin, ratio_strap_hi, ratio_strap_lo,
            output_layout_strap_hi, output_layout_strap_lo} <= v;
    endtask : set_straps
    // one-cycle low pulse after a strap change
    task automatic pulse(input logic use_start);
        @(posedge hclk);
        if (use_start) start_n <= 1'b0;
        else sync_req_n <= 1'b0;
        @(posedge hclk);
        start_n <= 1'b1;
        sync_req_n <= 1'b1;
    endtask : pulse
    // hard reset held low for n cycles
    task automatic hard_reset(input int n);
        @(posedge hclk);
        hard_reset_n <= 1'b0;
        repeat (n) @(posedge hclk);
        hard_reset_n <= 1'b1;
    endtask : hard_reset
endmodule : strap_host_model
`default_nettype wire

//--- testbench/adc_pin_strap_config_test.sv
// self-checking bench of the strap front end
`timescale 1ns/1ps
`default_nettype none
module adc_pin_strap_config_test;
    import cfg_pkg::*;
    logic hclk = 1'b0;
    logic hresetn, ce, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, r, w;
    logic [1:0] htrans, layout_code;
    logic [2:0] hsize;
    logic hreadyout, hresp, serial_ctrl_mode, cfg_ready, filter_sinc5;
    logic serial_result_lanes_shared, cfg_apply;
    logic [10:0] dec_ratio;
    logic [7:0] ain_precharge_en, ref_precharge_en;
    wire logic ctrl_select_pin, filter_sel_pin, ratio_strap_hi;
    wire logic ratio_strap_lo, output_layout_strap_hi;
    wire logic output_layout_strap_lo, start_n, sync_req_n, hard_reset_n;
    logic [31:0] exp_q[$];
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    integer seed = 32'h9081;
    logic [4:0] v;

    always #4 hclk = ~hclk;

    adc_pin_strap_config adc_pin_strap_config_i (.hclk, .hresetn, .ce,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ctrl_select_pin,
        .filter_sel_pin, .ratio_strap_hi, .ratio_strap_lo,
        .output_layout_strap_hi, .output_layout_strap_lo, .start_n,
        .sync_req_n, .hard_reset_n, .serial_ctrl_mode, .cfg_ready,
        .filter_sinc5, .dec_ratio, .layout_code, .serial_result_lanes_shared,
        .ain_precharge_en, .ref_precharge_en, .cfg_apply);
    strap_host_model strap_host_model_i (.hclk, .ctrl_select_pin,
        .filter_sel_pin, .ratio_strap_hi, .ratio_strap_lo,
        .output_layout_strap_hi, .output_layout_strap_lo, .start_n,
        .sync_req_n, .hard_reset_n);

    task automatic check(input logic [31:0] seen, exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h exp %h", $time, msg,
                seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // one single-word bus transfer, waits on ready in both phases
    task automatic bus(input logic wr, input logic [31:0] a, d,
        output logic [31:0] rd);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr, hsize} <= {1'b1, 2'h2, wr, a, 3'h2};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    function automatic logic [10:0] rat(input logic [1:0] c);
        return (c == 2'h3) ? 11'h400 : (11'h020 << c);
    endfunction : rat
    // expected outputs {lanes, filter, ratio, layout, ain, ref}
    function automatic logic [31:0] exp_of(input logic [23:0] x);
        return {1'b0, x[4:3] != 2'h0, x[0], rat(x[2:1]), x[4:3], x[15:8],
            x[23:16]};
    endfunction : exp_of
    function automatic logic [31:0] exp_pin(input logic [4:0] s);
        return exp_of({8'h00, 8'hFF, 3'h0, s[1:0], s[3:2], s[4]});
    endfunction : exp_pin
    task automatic wait_done();
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge hclk);
        check(32'(exp_q.size()), 32'h0, "apply missing");
    endtask : wait_done

    // compares each applied configuration with the oldest note
    always @(posedge hclk) begin
        if (cfg_apply === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0, "unexpected apply");
            end else begin
                check({1'b0, serial_result_lanes_shared, filter_sinc5,
                    dec_ratio, layout_code, ain_precharge_en,
                    ref_precharge_en}, exp_q.pop_front(),
                    "applied config");
            end
        end
    end
    // bounds the whole run
    always @(posedge hclk) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        {hresetn, ce, hsel, hwrite, haddr, htrans} = {1'b0, 1'b1, 36'h0};
        {hsize, hwdata} = {3'h2, 32'h0};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 32'h04, 32'h0, r);
        check(r, 32'h0000FF00, "serial config reset");
        bus(1'b0, 32'h20, 32'h0, r);
        check(r, 32'h0, "unmapped read");
        bus(1'b0, 32'h08, 32'h0, r);
        check(r & 32'h7, 32'h2, "waiting for reset");
        check({30'h0, cfg_ready, hresp}, 32'h0, "not ready, okay");
        strap_host_model_i.pulse(1'b1);
        repeat (4) @(posedge hclk);
        check({21'h0, dec_ratio}, 32'h20, "no apply before reset");
        $display("test reset done");
        v = 5'($random(seed));
        strap_host_model_i.set_straps(v);
        exp_q.push_back(exp_pin(v));
        strap_host_model_i.hard_reset(3);
        wait_done();
        $display("test hard reset done");
        for (int i = 0; i < 8; i++) begin
            v = {i[2], i[1:0], 2'($random(seed))};
            strap_host_model_i.set_straps(v);
            repeat (3) @(posedge hclk);
            exp_q.push_back(exp_pin(v));
            strap_host_model_i.pulse(i[0]);
            wait_done();
        end
        $display("test strap sweep done");
        @(posedge hclk);
        ce <= 1'b0;
        repeat (2) @(posedge hclk);
        check({31'h0, hreadyout}, 32'h0, "stall while disabled");
        ce <= 1'b1;
        exp_q.push_back(exp_pin(v));
        bus(1'b1, 32'h00, 32'h1, r);
        wait_done();
        exp_q.push_back(exp_pin(v));
        bus(1'b1, 32'h00, 32'h2, r);
        wait_done();
        $display("test soft reset and sync done");
        hresetn <= 1'b0;
        strap_host_model_i.ctrl_select_pin <= 1'b1;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check({31'h0, serial_ctrl_mode}, 32'h1, "serial chosen");
        exp_q.push_back(exp_of(24'h00FF00));
        bus(1'b1, 32'h00, 32'h1, r);
        wait_done();
        w = $random(seed);
        bus(1'b1, 32'h04, w, r);
        exp_q.push_back(exp_of(w[23:0]));
        bus(1'b1, 32'h00, 32'h2, r);
        wait_done();
        bus(1'b0, 32'h0C, 32'h0, r);
        check(r, w & 32'h00FFFF1F, "active readback");
        strap_host_model_i.ctrl_select_pin <= 1'b0;
        exp_q.push_back(exp_of(24'h00FF00));
        strap_host_model_i.hard_reset(2);
        wait_done();
        check({31'h0, serial_ctrl_mode}, 32'h1, "method kept");
        $display("test serial control done");
        summarize();
    end
endmodule : adc_pin_strap_config_test

bind adc_pin_strap_config adc_pin_strap_config_assertions chk_i (.hclk,
    .hresetn, .ce, .start_n, .filter_sel_pin, .ratio_strap_hi,
    .ratio_strap_lo, .serial_ctrl_mode, .cfg_ready, .filter_sinc5,
    .dec_ratio, .layout_code, .serial_result_lanes_shared,
    .ain_precharge_en, .ref_precharge_en, .cfg_apply);
`default_nettype wire
